// file: design/rmd_defs.svh
// register map, field positions, code groups and fifo sizing for rmd_top
// assumes it is included by bare name inside the design files
`ifndef RMD_DEFS_SVH
`define RMD_DEFS_SVH
`define RMD_A_CTRL 8'h00
`define RMD_A_PAT1 8'h04
`define RMD_A_PAT2 8'h08
`define RMD_A_STAT 8'h0C
`define RMD_A_CNT 8'h10
`define RMD_C_RM 0
`define RMD_C_DEC 1
`define RMD_C_DW 2
`define RMD_C_MODE 5:3
`define RMD_CTRL_RST 6'h06
`define RMD_PAT_RST 20'h3_D0FA
`define RMD_LO_SYM 9:0
`define RMD_HI_SYM 19:10
`define RMD_K307 10'h1E8
`define RMD_K285 10'h0FA
`define RMD_K285_DEC 8'hBC
`define RMD_PPM 300
`define RMD_DEPTH 8
`define RMD_FULL_LVL 4'h7
`define RMD_HI_LVL 4'h6
`define RMD_LO_LVL 4'h2
`define RMD_ZERO_LVL 4'h0
`endif

// file: design/rmd_pkg.sv
// types shared by the rate matcher and decoder
// assumes rmd_defs.svh is not needed here
package rmd_pkg;
  typedef enum logic [2:0] {
    RMD_BASIC, RMD_PCIE, RMD_XAUI, RMD_GIGE, RMD_SRIO
  } rmd_mode_t;
  typedef struct packed {
    logic valid;
    logic [19:0] data;
  } rmd_word_t;
  typedef struct packed {
    logic ins_ok;
    logic pat;
    logic [19:0] data;
  } rmd_ent_t;
  typedef struct packed {
    logic err;
    logic k;
    logic rd;
    logic [7:0] d;
  } rmd_dres_t;
  typedef struct packed {
    logic valid;
    logic [19:0] data;
    logic [1:0] ctrl;
    logic [1:0] err;
  } rmd_dec_t;
endpackage

// file: design/rmd_top.sv
// rate match fifo (double-width) and cascaded 8b/10b decoder
// assumes aligner, register master and fabric share core_clk
`timescale 1ns/1ps
`include "rmd_defs.svh"
// How it works
// - fifo depth and thresholds absorb up to 300 ppm clock offset
// - two programmable 20-bit patterns, control plus skip symbol
// - no insertion or deletion before the aligner reports sync
// - after control then skip, add or drop skips only in pairs
// - drop as many skip pairs per cluster as overflow needs
// - drop a pair only when both halves of one word are skips
// - insert skip pairs as needed, after a word whose high half is a skip
// - separate deletion and insertion pulses to the fabric
// - separate full and empty flags to the fabric
// - word that would fill is dropped, full flagged with next word
// - empty fifo outputs k30.7 pair with empty flag beside it
// - decoder fed by rate matcher when enabled, else aligner
// - single width decodes 10 bits into 8 data plus one flag
// - decoding follows the standard 8b/10b table and disparity
// - decoder forced on in protocol modes, optional in basic
// - flag high for the 12 control groups, low for data
// - k28.5 decodes to bc with its flag in the same cycle
// - low group decoded first, its disparity seeds the high group
// - double width gives 16 data bits and a 2-bit flag per byte
// - double width only in basic double-width mode, optional
module rmd_top import rmd_pkg::*; (
  input wire logic core_clk, // 20 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire rmd_word_t al_word, // aligned word from aligner
  input wire logic al_sync, // aligner sync achieved
  input wire logic rd_req, // fabric takes one fifo word
  output rmd_dec_t rx_out, // decoded word and flags
  output logic rm_deleted, // skip pair deleted pulse
  output logic rm_inserted, // skip pair inserted pulse
  output logic rm_full, // fifo full flag
  output logic rm_empty // fifo empty flag
);
  logic [5:0] ctrl_q;
  logic [19:0] pat_q [2];
  logic [31:0] rdata_q;
  rmd_mode_t mode;
  logic dec_on, dw_on, rm_on;
  logic [2:0] st_q, st_lo, st_hi;
  logic [3:0] wp_q, rp_q, lvl;
  rmd_ent_t mem_q [`RMD_DEPTH];
  logic wr, del_ok, del, disc, push, rd, ins, pop, fill;
  logic last_ok_q, last_pat_q, arm_q, del_q, ins_q, full_q, empty_q;
  logic [15:0] del_cnt_q, ins_cnt_q;
  rmd_word_t ro_q, din;
  rmd_dres_t r0, r1;
  logic rd_q;
  rmd_dec_t out_q;

  // one step of cluster tracking: {in cluster, ctrl seen, pattern}
  function automatic logic [2:0] cl_step(logic [2:0] st, logic [9:0] s);
    cl_step = 3'h0;
    if (s == pat_q[0][`RMD_LO_SYM]) begin
      cl_step = 3'h2;
    end else if (s == pat_q[1][`RMD_LO_SYM]) begin
      cl_step = 3'h3;
    end else if ((st[2] || st[1]) && s == pat_q[st[0]][`RMD_HI_SYM]) begin
      cl_step = {2'h2, st[0]};
    end
  endfunction

  // 10-bit group to byte, control flag and ending disparity
  function automatic rmd_dres_t dec10(logic [9:0] c, logic rdi);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r6;
    dec10 = '0;
    s6 = c[9:4];
    s4 = c[3:0];
    r6 = rdi;
    // k28 positive form carries inverted fghj
    if (s6 == 6'h30) begin
      s4 = ~c[3:0];
    end
    case (s6)
      6'b100111, 6'b011000: dec10.d[4:0] = 5'h00;
      6'b011101, 6'b100010: dec10.d[4:0] = 5'h01;
      6'b101101, 6'b010010: dec10.d[4:0] = 5'h02;
      6'b110001: dec10.d[4:0] = 5'h03;
      6'b110101, 6'b001010: dec10.d[4:0] = 5'h04;
      6'b101001: dec10.d[4:0] = 5'h05;
      6'b011001: dec10.d[4:0] = 5'h06;
      6'b111000, 6'b000111: dec10.d[4:0] = 5'h07;
      6'b111001, 6'b000110: dec10.d[4:0] = 5'h08;
      6'b100101: dec10.d[4:0] = 5'h09;
      6'b010101: dec10.d[4:0] = 5'h0A;
      6'b110100: dec10.d[4:0] = 5'h0B;
      6'b001101: dec10.d[4:0] = 5'h0C;
      6'b101100: dec10.d[4:0] = 5'h0D;
      6'b011100: dec10.d[4:0] = 5'h0E;
      6'b010111, 6'b101000: dec10.d[4:0] = 5'h0F;
      6'b011011, 6'b100100: dec10.d[4:0] = 5'h10;
      6'b100011: dec10.d[4:0] = 5'h11;
      6'b010011: dec10.d[4:0] = 5'h12;
      6'b110010: dec10.d[4:0] = 5'h13;
      6'b001011: dec10.d[4:0] = 5'h14;
      6'b101010: dec10.d[4:0] = 5'h15;
      6'b011010: dec10.d[4:0] = 5'h16;
      6'b111010, 6'b000101: dec10.d[4:0] = 5'h17;
      6'b110011, 6'b001100: dec10.d[4:0] = 5'h18;
      6'b100110: dec10.d[4:0] = 5'h19;
      6'b010110: dec10.d[4:0] = 5'h1A;
      6'b110110, 6'b001001: dec10.d[4:0] = 5'h1B;
      6'b001110, 6'b001111, 6'b110000: dec10.d[4:0] = 5'h1C;
      6'b101110, 6'b010001: dec10.d[4:0] = 5'h1D;
      6'b011110, 6'b100001: dec10.d[4:0] = 5'h1E;
      6'b101011, 6'b010100: dec10.d[4:0] = 5'h1F;
      default: dec10.err = 1'b1;
    endcase
    case (s4)
      4'b1011, 4'b0100: dec10.d[7:5] = 3'h0;
      4'b1001: dec10.d[7:5] = 3'h1;
      4'b0101: dec10.d[7:5] = 3'h2;
      4'b1100, 4'b0011: dec10.d[7:5] = 3'h3;
      4'b1101, 4'b0010: dec10.d[7:5] = 3'h4;
      4'b1010: dec10.d[7:5] = 3'h5;
      4'b0110: dec10.d[7:5] = 3'h6;
      4'b1110, 4'b0001, 4'b0111, 4'b1000: dec10.d[7:5] = 3'h7;
      default: dec10.err = 1'b1;
    endcase
    // twelve control groups: k28.x plus k23/27/29/30.7
    dec10.k = (s6 == 6'h0F) || (s6 == 6'h30) ||
      ((c[3:0] == 4'h7 || c[3:0] == 4'h8) &&
       (s6 == 6'h3A || s6 == 6'h05 || s6 == 6'h36 || s6 == 6'h09 ||
        s6 == 6'h2E || s6 == 6'h11 || s6 == 6'h1E || s6 == 6'h21));
    // running disparity after each sub-block
    if ($countones(s6) > 3) begin
      dec10.err = dec10.err | rdi;
      r6 = 1'b1;
    end else if ($countones(s6) < 3) begin
      dec10.err = dec10.err | ~rdi;
      r6 = 1'b0;
    end
    dec10.rd = r6;
    if ($countones(c[3:0]) > 2) begin
      dec10.err = dec10.err | r6;
      dec10.rd = 1'b1;
    end else if ($countones(c[3:0]) < 2) begin
      dec10.err = dec10.err | ~r6;
      dec10.rd = 1'b0;
    end
  endfunction

  // effective configuration
  assign mode = rmd_mode_t'(ctrl_q[`RMD_C_MODE]);
  assign dec_on = (mode != RMD_BASIC) || ctrl_q[`RMD_C_DEC];
  assign dw_on = (mode == RMD_BASIC) && ctrl_q[`RMD_C_DW];
  assign rm_on = ctrl_q[`RMD_C_RM] && dw_on && dec_on;

  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= `RMD_CTRL_RST;
      pat_q[0] <= `RMD_PAT_RST;
      pat_q[1] <= `RMD_PAT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `RMD_A_CTRL: ctrl_q <= reg_wdata[5:0];
        `RMD_A_PAT1: pat_q[0] <= reg_wdata[19:0];
        `RMD_A_PAT2: pat_q[1] <= reg_wdata[19:0];
        default: ;
      endcase
    end
  end

  // register reads, unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RMD_A_CTRL: rdata_q <= {26'h000_0000, ctrl_q};
        `RMD_A_PAT1: rdata_q <= {12'h000, pat_q[0]};
        `RMD_A_PAT2: rdata_q <= {12'h000, pat_q[1]};
        `RMD_A_STAT: rdata_q <= {25'h000_0000, rm_on, arm_q, al_sync, lvl};
        `RMD_A_CNT: rdata_q <= {ins_cnt_q, del_cnt_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // write side decisions
  assign lvl = wp_q - rp_q;
  assign wr = rm_on && al_word.valid;
  assign st_lo = cl_step(st_q, al_word.data[`RMD_LO_SYM]);
  assign st_hi = cl_step(st_lo, al_word.data[`RMD_HI_SYM]);
  assign del_ok = st_lo[2] && st_hi[2];
  assign del = wr && al_sync && del_ok && lvl >= `RMD_HI_LVL;
  assign disc = wr && !del && lvl == `RMD_FULL_LVL;
  assign push = wr && !del && !disc;

  // cluster tracker follows every aligned word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= 3'h0;
    end else if (al_word.valid) begin
      st_q <= st_hi;
    end
  end

  // fifo storage and write pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_q <= 4'h0;
    end else if (push) begin
      mem_q[wp_q[2:0]] <= '{ins_ok: st_hi[2], pat: st_hi[0],
                            data: al_word.data};
      wp_q <= wp_q + 4'h1;
    end
  end

  // read side decisions
  assign rd = rm_on && rd_req;
  assign ins = rd && al_sync && last_ok_q && lvl <= `RMD_LO_LVL;
  assign pop = rd && !ins && lvl != `RMD_ZERO_LVL;
  assign fill = rd && !ins && lvl == `RMD_ZERO_LVL;

  // output word: popped entry, inserted skip pair or filler
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rp_q <= 4'h0;
      ro_q <= '0;
      last_ok_q <= 1'b0;
      last_pat_q <= 1'b0;
    end else begin
      ro_q.valid <= rd;
      if (ins) begin
        ro_q.data <= {2{pat_q[last_pat_q][`RMD_HI_SYM]}};
      end else if (pop) begin
        ro_q.data <= mem_q[rp_q[2:0]].data;
        last_ok_q <= mem_q[rp_q[2:0]].ins_ok;
        last_pat_q <= mem_q[rp_q[2:0]].pat;
        rp_q <= rp_q + 4'h1;
      end else if (fill) begin
        ro_q.data <= {`RMD_K307, `RMD_K307};
        last_ok_q <= 1'b0;
      end
    end
  end

  // event and status flags, a new discard wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      del_q <= 1'b0;
      ins_q <= 1'b0;
      full_q <= 1'b0;
      empty_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      del_q <= del;
      ins_q <= ins;
      empty_q <= fill;
      full_q <= wr && !disc && arm_q;
      if (disc) begin
        arm_q <= 1'b1;
      end else if (wr) begin
        arm_q <= 1'b0;
      end
    end
  end
  assign rm_deleted = del_q;
  assign rm_inserted = ins_q;
  assign rm_full = full_q;
  assign rm_empty = empty_q;

  // event counters for software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      del_cnt_q <= 16'h0000;
      ins_cnt_q <= 16'h0000;
    end else begin
      del_cnt_q <= del_cnt_q + {15'h0000, del};
      ins_cnt_q <= ins_cnt_q + {15'h0000, ins};
    end
  end

  // decoder source and cascade
  assign din = rm_on ? ro_q : al_word;
  assign r0 = dec10(din.data[`RMD_LO_SYM], rd_q);
  assign r1 = dec10(din.data[`RMD_HI_SYM], r0.rd);

  // registered decoder output keeps bytes and flags together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_q <= 1'b0;
      out_q <= '0;
    end else begin
      out_q.valid <= din.valid;
      if (din.valid) begin
        if (!dec_on) begin
          out_q <= '{valid: 1'b1, data: din.data, ctrl: 2'h0, err: 2'h0};
        end else if (dw_on) begin
          out_q <= '{valid: 1'b1, data: {4'h0, r1.d, r0.d},
                     ctrl: {r1.k, r0.k}, err: {r1.err, r0.err}};
          rd_q <= r1.rd;
        end else begin
          out_q <= '{valid: 1'b1, data: {12'h000, r0.d},
                     ctrl: {1'b0, r0.k}, err: {1'b0, r0.err}};
          rd_q <= r0.rd;
        end
      end
    end
  end
  assign rx_out = out_q;

  // checks on the rate matcher and decoder
  property p_del_sync;
    @(posedge core_clk) disable iff (rst)
      rm_deleted |-> $past(al_sync) && $past(rm_on);
  endproperty
  a_del_sync: assert property (p_del_sync) else $error("delete no sync");
  property p_del_pair;
    @(posedge core_clk) disable iff (rst)
      del |-> al_word.data[`RMD_HI_SYM] == al_word.data[`RMD_LO_SYM] &&
        lvl >= `RMD_HI_LVL;
  endproperty
  a_del_pair: assert property (p_del_pair) else $error("bad delete");
  property p_ins_lvl;
    @(posedge core_clk) disable iff (rst)
      ins |=> rm_inserted && $past(lvl) <= `RMD_LO_LVL &&
        ro_q.data[`RMD_HI_SYM] == ro_q.data[`RMD_LO_SYM];
  endproperty
  a_ins_lvl: assert property (p_ins_lvl) else $error("bad insert");
  property p_disc;
    @(posedge core_clk) disable iff (rst)
      disc && !pop |=> lvl == $past(lvl);
  endproperty
  a_disc: assert property (p_disc) else $error("full word kept");
  // helper: a discard still waiting for the next accepted word
  logic full_pend_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      full_pend_q <= 1'b0;
    end else if (wr) begin
      full_pend_q <= disc;
    end
  end
  property p_full_next;
    @(posedge core_clk) disable iff (rst)
      wr && !disc |=> rm_full == $past(full_pend_q);
  endproperty
  a_full_next: assert property (p_full_next) else $error("no full");
  property p_fill;
    @(posedge core_clk) disable iff (rst)
      fill |=> rm_empty && ro_q.data == {`RMD_K307, `RMD_K307};
  endproperty
  a_fill: assert property (p_fill) else $error("no filler");
  property p_k285;
    @(posedge core_clk) disable iff (rst)
      din.valid && dec_on && din.data[`RMD_LO_SYM] == `RMD_K285 |=>
        rx_out.data[7:0] == `RMD_K285_DEC && rx_out.ctrl[0];
  endproperty
  a_k285: assert property (p_k285) else $error("k28.5 wrong");
  property p_sw;
    @(posedge core_clk) disable iff (rst)
      din.valid && !dw_on |=> rx_out.ctrl[1] == 1'b0;
  endproperty
  a_sw: assert property (p_sw) else $error("high flag single");
  property p_lvl;
    @(posedge core_clk) disable iff (rst)
      lvl <= `RMD_FULL_LVL && (rm_on || (!del && !ins));
  endproperty
  a_lvl: assert property (p_lvl) else $error("fifo overrun");
  c_del: cover property (@(posedge core_clk) disable iff (rst) del);
  c_ins: cover property (@(posedge core_clk) disable iff (rst) ins);
  c_fill: cover property (@(posedge core_clk) disable iff (rst) fill);
  c_disc: cover property (@(posedge core_clk) disable iff (rst) disc);
endmodule

// file: bench/rmd_align_model.sv
// aligner stand-in: presents one word per send and a sync status
// assumes the bench drives send, word and sync_en after core_clk rises
`timescale 1ns/1ps
module rmd_align_model import rmd_pkg::*; (
  input wire logic core_clk, // shared clock
  input wire logic rst, // sync reset, high
  input wire logic send, // present word in the next cycle
  input wire logic [19:0] word, // {high symbol, low symbol}
  input wire logic sync_en, // sync achieved request
  output rmd_word_t al_word, // aligned word to the block
  output logic al_sync // sync status to the block
);
  // idle cycles carry inverted data so no stale word looks valid
  always_ff @(posedge core_clk) begin
    if (rst) begin
      al_word <= '0;
    end else if (send) begin
      al_word <= {1'b1, word};
    end else begin
      al_word <= {1'b0, ~al_word.data};
    end
  end
  // sync status follows the request by one cycle
  always_ff @(posedge core_clk) begin
    al_sync <= sync_en & ~rst;
  end
endmodule

// file: bench/rate_match_and_8b10b_decode_tb.sv
// self-checking bench for rmd_top: registers, decoder, rate match fifo
// assumes rmd_align_model feeds the aligner side on core_clk
`timescale 1ns/1ps
module rate_match_and_8b10b_decode_tb import rmd_pkg::*;;
  logic core_clk, rst, reg_wr, reg_rd, rd_req, send, sync_en, al_sync;
  logic rm_deleted, rm_inserted, rm_full, rm_empty;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [19:0] word;
  rmd_word_t al_word;
  rmd_dec_t rx_out;
  int fail_count, cmp_count;
  bit rp;
  localparam logic [19:0] DW = 20'hA_A955; // {D21.5, D10.2}
  localparam logic [19:0] CW = 20'h3_D0FA; // {skip K28.0, ctrl K28.5}
  localparam logic [19:0] SW = 20'h3_D0F4; // {skip, skip}

  rmd_align_model al_u (.core_clk(core_clk), .rst(rst), .send(send),
    .word(word), .sync_en(sync_en), .al_word(al_word), .al_sync(al_sync));
  rmd_top dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .al_word(al_word), .al_sync(al_sync),
    .rd_req(rd_req), .rx_out(rx_out), .rm_deleted(rm_deleted),
    .rm_inserted(rm_inserted), .rm_full(rm_full), .rm_empty(rm_empty));

  // clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    sync_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  // word reaches the block one cycle after send, results one later
  task automatic put(logic [19:0] w);
    @(posedge core_clk);
    word <= w;
    send <= 1'b1;
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic putd(logic [19:0] w, logic [19:0] d, logic [1:0] c);
    put(w);
    chk("rx valid", rx_out.valid, 1'b1);
    chk("rx data", rx_out.data, d);
    chk("rx ctrl", rx_out.ctrl, c);
    chk("rx err", rx_out.err, 2'b00);
  endtask

  task automatic putf(logic [19:0] w, logic del, logic full);
    put(w);
    chk("deleted", rm_deleted, del);
    chk("full", rm_full, full);
  endtask

  task automatic pullf(logic ins, logic emp, logic [19:0] d, bit cd);
    @(posedge core_clk);
    rd_req <= 1'b1;
    @(posedge core_clk);
    rd_req <= 1'b0;
    #1;
    chk("inserted", rm_inserted, ins);
    chk("empty", rm_empty, emp);
    @(posedge core_clk);
    #1;
    if (cd) begin
      chk("fifo out data", rx_out.data, d);
      chk("fifo out ctrl", rx_out.ctrl, 2'b11);
    end
  endtask

  task automatic lvl(logic [31:0] e);
    rd(8'h0C);
    // level, sync seen, full armed and rate match active
    chk("fifo status", rdv & 32'h0000_007F, e);
  endtask

  // reset values, pattern storage, unmapped address
  task automatic t_regs();
    rd(8'h00);
    chk("ctrl reset", rdv, 32'h0000_0006);
    rd(8'h04);
    chk("pat1 reset", rdv, 32'h0003_D0FA);
    wr(8'h08, 32'h0003_D0F3);
    rd(8'h08);
    chk("pat2", rdv, 32'h0003_D0F3);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14);
    chk("unmapped", rdv, 32'h0000_0000);
    rd(8'h00);
    chk("ctrl kept", rdv, 32'h0000_0006);
  endtask

  // cascaded decode: low group's disparity seeds the high group
  task automatic t_dbl();
    putd({10'h305, 10'h0FA}, 20'h0_BCBC, 2'b11);
    putd({10'h2AA, 10'h0FA}, 20'h0_B5BC, 2'b01);
    putd({10'h155, 10'h2AA}, 20'h0_4AB5, 2'b00);
    put({10'h155, 10'h0FA});
    chk("rd error", rx_out.err, 2'b01);
  endtask

  // single width, forced decoder in protocol modes, decoder off
  task automatic t_single();
    do_reset();
    wr(8'h00, 32'h0000_0002);
    putd({10'h2AA, 10'h0FA}, 20'h0_00BC, 2'b01);
    putd({10'h0FA, 10'h2AA}, 20'h0_00B5, 2'b00);
    rp = 1'b1;
    for (int m = 1; m < 5; m++) begin
      wr(8'h00, {26'h0, m[2:0], 3'b100});
      putd({10'h2AA, rp ? 10'h305 : 10'h0FA}, 20'h0_00BC, 2'b01);
      rp = ~rp;
    end
    wr(8'h00, 32'h0000_0004);
    putd(DW, DW, 2'b00);
  endtask

  // rate match: sync gating, deletion, full, insertion, empty
  task automatic t_rate();
    do_reset();
    wr(8'h04, {12'h0, CW});
    wr(8'h00, 32'h0000_0007);
    repeat (5) putf(DW, 1'b0, 1'b0);
    putf(CW, 1'b0, 1'b0);
    putf(SW, 1'b0, 1'b0);
    lvl(32'h47);
    pullf(1'b0, 1'b0, 20'h0, 1'b0);
    @(posedge core_clk);
    sync_en <= 1'b1;
    putf(CW, 1'b0, 1'b0);
    putf(SW, 1'b1, 1'b0);
    putf(SW, 1'b1, 1'b0);
    lvl(32'h57);
    rd(8'h10);
    chk("del count", rdv & 32'h0000_FFFF, 32'h2);
    putf(DW, 1'b0, 1'b0);
    lvl(32'h77);
    pullf(1'b0, 1'b0, 20'h0, 1'b0);
    putf(DW, 1'b0, 1'b1);
    repeat (5) pullf(1'b0, 1'b0, 20'h0, 1'b0);
    lvl(32'h52);
    pullf(1'b1, 1'b0, 20'h0_1C1C, 1'b1);
    @(posedge core_clk);
    sync_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    repeat (2) pullf(1'b0, 1'b0, 20'h0, 1'b0);
    pullf(1'b0, 1'b1, 20'h0_FEFE, 1'b1);
    chk("full idle", rm_full, 1'b0);
  endtask

  // watchdog, far beyond the roughly 150 cycles the tests take
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    conclude();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_req = 1'b0;
    send = 1'b0;
    sync_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    word = 20'h0_0000;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_dbl();
    t_single();
    t_rate();
    conclude();
  end
endmodule
